//--- rtl/regulator_control_pkg.sv
// constants shared by the regulator control logic and its sequencer
// assumes a single 20 MHz device clock; analog parts sit outside this logic
package regulator_control_pkg;

  // ==========================================================
  // regulator population
  localparam int NUM_BUCK = 3;
  localparam int NUM_LINEAR = 4;
  localparam int NUM_REG = NUM_BUCK + NUM_LINEAR;

  // ==========================================================
  // voltage code layout: range in the upper half, step in the lower
  localparam int CODE_W = 6;
  localparam int RANGE_LSB = 3;
  localparam int STEP_W = 3;
  localparam logic [CODE_W-1:0] CODE_MIN = 6'h00; // 0.600 V
  localparam logic [CODE_W-1:0] CODE_MAX = 6'h3F; // 3.900 V

  // ==========================================================
  // turn-on delay: 3-bit code, 0 ms then 2^code ms
  localparam int DELAY_W = 3;
  localparam int DELAY_MS_W = 8;
  localparam logic [DELAY_W-1:0] DELAY_CODE_NONE = 3'h0;
  localparam logic [DELAY_MS_W-1:0] DELAY_MS_ONE = 8'h01;
  localparam logic [DELAY_MS_W-1:0] DELAY_MS_ZERO = 8'h00;

  // ==========================================================
  // timing at the device clock
  localparam longint CLK_HZ = 20_000_000;
  localparam longint MS_PER_S = 1000;
  localparam longint US_PER_S = 1_000_000;
  localparam longint SOFT_START_US = 400;
  localparam int MS_CYCLES = int'(CLK_HZ / MS_PER_S);
  localparam int SOFT_START_CYCLES = int'((SOFT_START_US * CLK_HZ + US_PER_S - 1) / US_PER_S);
  localparam int RAMP_W = 16;
  localparam int TICK_W = 32;

  // ==========================================================
  // power-good comparator thresholds, percent under target (analog trim)
  localparam int BUCK_PG_PCT = 7;
  localparam int LINEAR_PG_PCT = 11;
  localparam int LOW_BIAS_SAVING_PCT = 16;

  // ==========================================================
  // per-regulator sequencing states
  typedef enum logic [1:0] {
    REG_OFF = 2'b00,
    REG_WAIT = 2'b01,
    REG_RAMP = 2'b10,
    REG_ON = 2'b11
  } reg_state_e;

endpackage

//--- rtl/regulator_sequencer.sv
// one regulator's enable edge detector, turn-on delay and soft-start timer
// assumes enable_bit and delay_code come from logic on mclk; ms_tick is a
// one-cycle pulse every millisecond from the shared divider
`timescale 1ns/1ps
module regulator_sequencer #(
  parameter int RAMP_CYCLES = 0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic enable_bit,
  input wire logic [regulator_control_pkg::DELAY_W-1:0] delay_code,
  input wire logic ms_tick,
  output logic internal_enable,
  output logic regulated
);

  regulator_control_pkg::reg_state_e state_q, state_d;
  logic prev_q, prev_d;
  logic armed_q, armed_d;
  logic [regulator_control_pkg::DELAY_MS_W-1:0] ms_cnt_q, ms_cnt_d;
  logic [regulator_control_pkg::RAMP_W-1:0] ramp_cnt_q, ramp_cnt_d;
  logic rise;
  logic fall;
  logic [regulator_control_pkg::DELAY_MS_W-1:0] delay_ms;
  localparam int RW = regulator_control_pkg::RAMP_W;

  // ==========================================================
  // next state: only edges act, a level alone never does
  always_comb
  begin
    prev_d = enable_bit;
    armed_d = 1'b1; // level seen at release is not an edge
    rise = armed_q & enable_bit & ~prev_q;
    fall = armed_q & ~enable_bit & prev_q;
    if (delay_code == regulator_control_pkg::DELAY_CODE_NONE)
      delay_ms = regulator_control_pkg::DELAY_MS_ZERO;
    else
      delay_ms = regulator_control_pkg::DELAY_MS_ONE << delay_code;
    state_d = state_q;
    ms_cnt_d = ms_cnt_q;
    ramp_cnt_d = ramp_cnt_q;
    case (state_q)
      regulator_control_pkg::REG_OFF:
      begin
        if (rise)
        begin
          // timer starts at the enabling edge
          if (delay_ms != regulator_control_pkg::DELAY_MS_ZERO)
          begin
            state_d = regulator_control_pkg::REG_WAIT;
            ms_cnt_d = delay_ms;
          end
          else if (RAMP_CYCLES == 0)
            state_d = regulator_control_pkg::REG_ON;
          else
          begin
            state_d = regulator_control_pkg::REG_RAMP;
            ramp_cnt_d = RW'(RAMP_CYCLES - 1);
          end
        end
      end
      regulator_control_pkg::REG_WAIT:
      begin
        // free-running tick: one extra tick so the delay is never short
        if (ms_tick)
        begin
          if (ms_cnt_q == regulator_control_pkg::DELAY_MS_ZERO)
          begin
            if (RAMP_CYCLES == 0)
              state_d = regulator_control_pkg::REG_ON;
            else
            begin
              state_d = regulator_control_pkg::REG_RAMP;
              ramp_cnt_d = RW'(RAMP_CYCLES - 1);
            end
          end
          else
            ms_cnt_d = ms_cnt_q - regulator_control_pkg::DELAY_MS_ONE;
        end
      end
      regulator_control_pkg::REG_RAMP:
      begin
        if (ramp_cnt_q == '0)
          state_d = regulator_control_pkg::REG_ON;
        else
          ramp_cnt_d = ramp_cnt_q - 1'b1;
      end
      regulator_control_pkg::REG_ON:
        state_d = regulator_control_pkg::REG_ON;
      default:
        state_d = regulator_control_pkg::REG_OFF;
    endcase
    // a disabling edge cancels a pending delay or ramp
    if (fall)
      state_d = regulator_control_pkg::REG_OFF;
  end

  // ==========================================================
  // state registers
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_q <= regulator_control_pkg::REG_OFF;
      prev_q <= 1'b0;
      armed_q <= 1'b0;
      ms_cnt_q <= '0;
      ramp_cnt_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      prev_q <= prev_d;
      armed_q <= armed_d;
      ms_cnt_q <= ms_cnt_d;
      ramp_cnt_q <= ramp_cnt_d;
    end
  end

  assign internal_enable = (state_q == regulator_control_pkg::REG_RAMP) ||
                           (state_q == regulator_control_pkg::REG_ON);
  assign regulated = (state_q == regulator_control_pkg::REG_ON);

endmodule

//--- rtl/regulator_control_logic.sv
// control logic for three step-down converters and four linear regulators
// assumes control bits arrive from the host register file on mclk; the bank
// select pin and power-good comparators are asynchronous and are synchronised
// What this block does
// - bank pin picks primary or alternate code
// - codes start at default, software may overwrite
// - only enable-bit edges switch regulators on/off
// - 3-bit delay code: 0 to 128 ms
// - mode bit forces PWM, else light-load saving
// - 6-bit code: range high, step low
// - converter power-good trips 7 percent low
// - linear power-good trips 11 percent low
// - unmasked power-good loss pulls interrupt low
// - interrupt holds until recovered or disabled, and status read
// - discharge path closes while disabled when enabled
// - low-quiescent bit selects reduced-bias mode
// - linear regulators hold one code, no pin
// - converters soft-start about 400 microseconds
`timescale 1ns/1ps
module regulator_control_logic #(
  parameter int MS_CYCLES = regulator_control_pkg::MS_CYCLES,
  parameter int SOFT_START_CYCLES = regulator_control_pkg::SOFT_START_CYCLES,
  parameter logic [17:0] BUCK_PRIMARY_DEFAULT = 18'h00000,
  parameter logic [17:0] BUCK_ALTERNATE_DEFAULT = 18'h00000,
  parameter logic [23:0] LINEAR_DEFAULT = 24'h000000
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic voltage_bank_select_pin,
  input wire logic [2:0] primary_code_wr,
  input wire logic [2:0] alternate_code_wr,
  input wire logic [3:0] linear_code_wr,
  input wire logic [5:0] code_wdata,
  input wire logic [6:0] enable_bit,
  input wire logic [20:0] delay_code,
  input wire logic [2:0] mode_bit,
  input wire logic [3:0] output_discharge_enable,
  input wire logic [3:0] low_quiescent_enable,
  input wire logic [6:0] fault_interrupt_unmask,
  input wire logic [6:0] power_good_comparator,
  input wire logic power_good_read,
  output logic [17:0] primary_voltage_code,
  output logic [17:0] alternate_voltage_code,
  output logic [23:0] linear_voltage_code,
  output logic [17:0] buck_target_code,
  output logic [6:0] internal_enable,
  output logic [6:0] regulated,
  output logic [2:0] forced_pwm,
  output logic [2:0] power_save_allowed,
  output logic [3:0] discharge_switch_on,
  output logic [3:0] low_bias_mode,
  output logic [6:0] power_good,
  output logic interrupt_request_low
);

  localparam int NB = regulator_control_pkg::NUM_BUCK;
  localparam int NL = regulator_control_pkg::NUM_LINEAR;
  localparam int NR = regulator_control_pkg::NUM_REG;
  localparam int CW = regulator_control_pkg::CODE_W;
  localparam int DW = regulator_control_pkg::DELAY_W;
  localparam int TW = regulator_control_pkg::TICK_W;

  // ==========================================================
  // input synchronisers for pin and comparator levels
  logic bank_meta_q;
  logic bank_sync_q;
  logic [NR-1:0] pg_meta_q;
  logic [NR-1:0] pg_sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      bank_meta_q <= 1'b0;
      bank_sync_q <= 1'b0;
      pg_meta_q <= '0;
      pg_sync_q <= '0;
    end
    else
    begin
      bank_meta_q <= voltage_bank_select_pin;
      bank_sync_q <= bank_meta_q;
      pg_meta_q <= power_good_comparator;
      pg_sync_q <= pg_meta_q;
    end
  end

  // comparators trip at 7 or 11 percent under target; threshold is analog
  assign power_good = pg_sync_q;

  // ==========================================================
  // millisecond tick divider shared by all delay timers
  logic [TW-1:0] tick_cnt_q, tick_cnt_d;
  logic ms_tick;

  always_comb
  begin
    ms_tick = (tick_cnt_q == TW'(MS_CYCLES - 1));
    tick_cnt_d = ms_tick ? '0 : tick_cnt_q + 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= tick_cnt_d;
  end

  // ==========================================================
  // voltage code registers
  logic [NB*CW-1:0] pri_q, pri_d;
  logic [NB*CW-1:0] alt_q, alt_d;
  logic [NL*CW-1:0] lin_q, lin_d;
  logic [NB*CW-1:0] target_q, target_d;

  // writes land per regulator; selection follows the synchronised pin
  always_comb
  begin
    pri_d = pri_q;
    alt_d = alt_q;
    lin_d = lin_q;
    for (int i = 0; i < NB; i++)
    begin
      if (primary_code_wr[i])
        pri_d[i*CW +: CW] = code_wdata;
      if (alternate_code_wr[i])
        alt_d[i*CW +: CW] = code_wdata;
    end
    for (int i = 0; i < NL; i++)
    begin
      if (linear_code_wr[i])
        lin_d[i*CW +: CW] = code_wdata;
    end
    target_d = bank_sync_q ? alt_q : pri_q;
  end

  // power-up values are the defaults
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pri_q <= BUCK_PRIMARY_DEFAULT;
      alt_q <= BUCK_ALTERNATE_DEFAULT;
      lin_q <= LINEAR_DEFAULT;
      target_q <= BUCK_PRIMARY_DEFAULT;
    end
    else
    begin
      pri_q <= pri_d;
      alt_q <= alt_d;
      lin_q <= lin_d;
      target_q <= target_d;
    end
  end

  // codes carry range in bits 5:3 and step in bits 2:0, unchanged here
  assign primary_voltage_code = pri_q;
  assign alternate_voltage_code = alt_q;
  assign linear_voltage_code = lin_q;
  assign buck_target_code = target_q;

  // ==========================================================
  // per-regulator enable sequencing
  for (genvar g = 0; g < NR; g++)
  begin : gen_seq
    regulator_sequencer #(
      .RAMP_CYCLES(g < NB ? SOFT_START_CYCLES : 0)
    ) u_seq (
      .mclk(mclk),
      .rst_n(rst_n),
      .enable_bit(enable_bit[g]),
      .delay_code(delay_code[g*DW +: DW]),
      .ms_tick(ms_tick),
      .internal_enable(internal_enable[g]),
      .regulated(regulated[g])
    );
  end

  // ==========================================================
  // operating options for converters and linear regulators
  logic [NB-1:0] pwm_q, pwm_d;
  logic [NL-1:0] dis_q, dis_d;
  logic [NL-1:0] lowbias_q, lowbias_d;

  // discharge only while off, registered one cycle late, so it overlaps a live output for its first cycle
  always_comb
  begin
    pwm_d = mode_bit;
    dis_d = output_discharge_enable & ~internal_enable[NR-1:NB];
    lowbias_d = low_quiescent_enable;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pwm_q <= '0;
      dis_q <= '0;
      lowbias_q <= '0;
    end
    else
    begin
      pwm_q <= pwm_d;
      dis_q <= dis_d;
      lowbias_q <= lowbias_d;
    end
  end

  assign forced_pwm = pwm_q;
  assign power_save_allowed = ~pwm_q;
  assign discharge_switch_on = dis_q;
  assign low_bias_mode = lowbias_q;

  // ==========================================================
  // output fault interrupt
  logic [NR-1:0] trip;
  logic [NR-1:0] trip_q, trip_d;
  logic [NR-1:0] fault_q, fault_d;
  logic [NR-1:0] read_seen_q, read_seen_d;
  logic irq_low_q, irq_low_d;

  // only a regulator past soft-start can fault; new trip beats any clear
  always_comb
  begin
    trip = fault_interrupt_unmask & regulated & ~pg_sync_q;
    trip_d = trip;
    for (int i = 0; i < NR; i++)
    begin
      fault_d[i] = (trip[i] & ~trip_q[i]) | (fault_q[i] & ~(
        (~internal_enable[i] | pg_sync_q[i]) &
        (read_seen_q[i] | power_good_read)));
      read_seen_d[i] = fault_d[i] & ~(trip[i] & ~trip_q[i]) &
        (read_seen_q[i] | power_good_read);
    end
    irq_low_d = ~|fault_d;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      trip_q <= '0;
      fault_q <= '0;
      read_seen_q <= '0;
      irq_low_q <= 1'b1;
    end
    else
    begin
      trip_q <= trip_d;
      fault_q <= fault_d;
      read_seen_q <= read_seen_d;
      irq_low_q <= irq_low_d;
    end
  end

  assign interrupt_request_low = irq_low_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_bank_alt;
    bank_sync_q |=> buck_target_code == $past(alt_q);
  endproperty
  a_bank_alt: assert property (p_bank_alt) else $error("alternate code not selected");

  property p_default_code;
    $rose(rst_n) |-> linear_voltage_code == LINEAR_DEFAULT &&
      primary_voltage_code == BUCK_PRIMARY_DEFAULT;
  endproperty
  a_default_code: assert property (p_default_code) else $error("codes not at default");

  property p_low_stays_off;
    (!enable_bit[0] && $past(!enable_bit[0])) |-> !internal_enable[0];
  endproperty
  a_low_stays_off: assert property (p_low_stays_off) else $error("on without edge");

  property p_fall_cancels;
    ($fell(enable_bit[3]) && $past(rst_n, 2)) |=> !internal_enable[3] && !regulated[3];
  endproperty
  a_fall_cancels: assert property (p_fall_cancels) else $error("disable edge ignored");

  property p_zero_delay;
    ($rose(enable_bit[3]) && $past(rst_n, 2) && !internal_enable[3] &&
      delay_code[3*DW +: DW] == regulator_control_pkg::DELAY_CODE_NONE) |=> regulated[3];
  endproperty
  a_zero_delay: assert property (p_zero_delay) else $error("zero delay not immediate");

  property p_delay_waits;
    ($rose(enable_bit[4]) && !internal_enable[4] &&
      delay_code[4*DW +: DW] != regulator_control_pkg::DELAY_CODE_NONE) |=>
      !internal_enable[4] [*8];
  endproperty
  a_delay_waits: assert property (p_delay_waits) else $error("turn-on delay cut short");

  property p_soft_start;
    $rose(internal_enable[0]) |-> !regulated[0] [*8];
  endproperty
  a_soft_start: assert property (p_soft_start) else $error("soft-start skipped");

  property p_mode;
    mode_bit[0] |=> forced_pwm[0] && !power_save_allowed[0];
  endproperty
  a_mode: assert property (p_mode) else $error("forced pwm not applied");

  property p_discharge;
    discharge_switch_on[1] |-> $past(output_discharge_enable[1]) && !$past(internal_enable[4]);
  endproperty
  a_discharge: assert property (p_discharge) else $error("discharge while enabled");

  property p_low_bias;
    ##1 low_bias_mode[1] == $past(low_quiescent_enable[1]);
  endproperty
  a_low_bias: assert property (p_low_bias) else $error("low bias mode mismatch");

  property p_linear_write;
    linear_code_wr[3] |=> linear_voltage_code[3*CW +: CW] == $past(code_wdata);
  endproperty
  a_linear_write: assert property (p_linear_write) else $error("linear code write lost");

  property p_irq_assert;
    (trip[3] && !trip_q[3]) |=> !interrupt_request_low;
  endproperty
  a_irq_assert: assert property (p_irq_assert) else $error("fault gave no interrupt");

  property p_irq_hold;
    (!interrupt_request_low && !power_good_read && !(|read_seen_q)) |=> !interrupt_request_low;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt released before read");

  c_irq: cover property (!interrupt_request_low ##[1:50] interrupt_request_low);
  c_regulated: cover property ($rose(regulated[0]));
  c_bank: cover property ($rose(bank_sync_q) ##1 buck_target_code != $past(buck_target_code));

endmodule

//--- testbench/host_model.sv
// host processor model: code writes, enable toggles and status reads
// assumes the same mclk as the control logic; drives just after rising edges
`timescale 1ns/1ps
module host_model (
  input wire logic mclk,
  output logic [6:0] enable_bit,
  output logic [9:0] code_wr,
  output logic [5:0] code_wdata,
  output logic power_good_read
);
  // ==========================================================
  // host state
  int gap = 1; // cycles between the two writes of a toggle; raise for a slow host
  initial
  begin
    enable_bit = 7'h20; // linear_three held high from the start: a static level
    code_wr = 10'h000;
    code_wdata = 6'h00;
    power_good_read = 1'b0;
  end

  // ==========================================================
  // access tasks
  // one-cycle write strobe; sel is {linear, alternate, primary}
  task automatic write_code(input logic [9:0] sel, input logic [5:0] data);
    @(posedge mclk);
    code_wr <= sel;
    code_wdata <= data;
    @(posedge mclk);
    code_wr <= 10'h000;
  endtask

  // inverse level first, so the wanted edge happens whatever the old level
  task automatic set_enable(input int idx, input logic level);
    @(posedge mclk);
    enable_bit[idx] <= !level;
    repeat (gap) @(posedge mclk);
    enable_bit[idx] <= level;
  endtask

  // status read pulse, one cycle
  task automatic read_status();
    @(posedge mclk);
    power_good_read <= 1'b1;
    @(posedge mclk);
    power_good_read <= 1'b0;
  endtask
endmodule

//--- testbench/testbench.sv
// self-checking bench for the regulator control logic
// assumes host_model drives host controls; comparators and pins driven here
`timescale 1ns/1ps
module testbench;
  // ==========================================================
  // signals
  localparam logic [17:0] PRI_DEF = 18'h2A5C3;
  localparam logic [17:0] ALT_DEF = 18'h15A3C;
  localparam logic [23:0] LIN_DEF = 24'hC30F96;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic pin = 1'b0;
  logic [20:0] delay_code = 21'h000000;
  logic [2:0] mode_bit = 3'h0;
  logic [3:0] dis_en = 4'h0;
  logic [3:0] lq_en = 4'h0;
  logic [6:0] unmask = 7'h00;
  logic [6:0] comp = 7'h7F;
  logic [9:0] code_wr;
  logic [6:0] enable_bit;
  logic [5:0] code_wdata;
  logic pg_read;
  logic [17:0] pri_code, alt_code, tgt_code;
  logic [23:0] lin_code;
  logic [6:0] int_en, regd, pg;
  logic [2:0] pwm, psave;
  logic [3:0] dis_on, low_bias;
  logic irq_low;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;

  // ==========================================================
  // instances; short ms and soft-start counts keep the run brief
  host_model host (.mclk(mclk), .enable_bit(enable_bit), .code_wr(code_wr),
    .code_wdata(code_wdata), .power_good_read(pg_read));
  regulator_control_logic #(.MS_CYCLES(20), .SOFT_START_CYCLES(16),
    .BUCK_PRIMARY_DEFAULT(PRI_DEF), .BUCK_ALTERNATE_DEFAULT(ALT_DEF),
    .LINEAR_DEFAULT(LIN_DEF)) DUT (
    .mclk(mclk), .rst_n(rst_n), .voltage_bank_select_pin(pin),
    .primary_code_wr(code_wr[2:0]), .alternate_code_wr(code_wr[5:3]),
    .linear_code_wr(code_wr[9:6]), .code_wdata(code_wdata), .enable_bit(enable_bit),
    .delay_code(delay_code), .mode_bit(mode_bit), .output_discharge_enable(dis_en),
    .low_quiescent_enable(lq_en), .fault_interrupt_unmask(unmask),
    .power_good_comparator(comp), .power_good_read(pg_read),
    .primary_voltage_code(pri_code), .alternate_voltage_code(alt_code),
    .linear_voltage_code(lin_code), .buck_target_code(tgt_code), .internal_enable(int_en),
    .regulated(regd), .forced_pwm(pwm), .power_save_allowed(psave),
    .discharge_switch_on(dis_on), .low_bias_mode(low_bias), .power_good(pg),
    .interrupt_request_low(irq_low));

  // ==========================================================
  // clock and hang guard
  initial
  begin
    forever #25 mclk = ~mclk;
  end

  // whole run is about 5700 cycles
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      miscompares++;
      final_report();
    end
  end

  // ==========================================================
  // helpers
  task automatic final_report();
    if (miscompares == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // sample just after the edge so that edge's updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // cycles until enable (which=0) or regulated (which=1) rises, bounded
  task automatic cycles_until(input int idx, input logic which, input int limit,
    output int n);
    n = 0;
    while ((which ? regd[idx] : int_en[idx]) !== 1'b1 && n < limit)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    int n;
    int ms;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    tick(2);
    check(pri_code, PRI_DEF);
    check(alt_code, ALT_DEF);
    check(lin_code, LIN_DEF);
    check(tgt_code, PRI_DEF);
    check(psave, 3'h7);
    check(irq_low, 1'b1);
    // code writes at the top code and into one alternate and one linear slot
    host.write_code(10'h007, 6'h3F);
    host.write_code(10'h010, 6'h2D);
    host.write_code(10'h200, 6'h15);
    tick(3);
    check(pri_code, 18'h3FFFF);
    check(alt_code, {ALT_DEF[17:12], 6'h2D, ALT_DEF[5:0]});
    check(lin_code, {6'h15, LIN_DEF[17:0]});
    check(tgt_code, 18'h3FFFF);
    check(int_en, 7'h00);
    @(posedge mclk);
    pin <= 1'b1;
    mode_bit <= 3'h5;
    dis_en <= 4'hF;
    lq_en <= 4'hA;
    tick(5);
    check(tgt_code, {ALT_DEF[17:12], 6'h2D, ALT_DEF[5:0]});
    check(pwm, 3'h5);
    check(psave, 3'h2);
    check(low_bias, 4'hA);
    check(dis_on, 4'hF);
    // every delay code on linear_one
    for (int code = 0; code < 8; code++)
    begin
      @(posedge mclk);
      delay_code[11:9] <= code[2:0];
      host.set_enable(3, 1'b1);
      cycles_until(3, 1'b0, 3000, n);
      ms = (code == 0) ? 0 : (1 << code);
      check(n >= ms * 20 && n <= ms * 20 + 23, 1'b1);
      tick(2);
      check(dis_on, 4'hE);
      host.set_enable(3, 1'b0);
      tick(3);
      check(int_en[3], 1'b0);
      check(dis_on, 4'hF);
    end
    // converter soft-start after a zero delay
    host.set_enable(0, 1'b1);
    cycles_until(0, 1'b0, 100, n);
    cycles_until(0, 1'b1, 100, n);
    check(n, 16);
    // slow host cancels a pending 8 ms delay
    @(posedge mclk);
    delay_code[14:12] <= 3'h3;
    delay_code[11:9] <= 3'h0;
    host.gap = 4;
    host.set_enable(4, 1'b1);
    tick(60);
    host.set_enable(4, 1'b0);
    host.gap = 1;
    cycles_until(4, 1'b0, 300, n);
    check(n, 300);
    // fault on linear_one, cleared by recovery after a read
    @(posedge mclk);
    unmask <= 7'h08;
    host.set_enable(3, 1'b1);
    tick(4);
    check(pg, 7'h7F);
    @(posedge mclk);
    comp[3] <= 1'b0;
    tick(5);
    check(pg[3], 1'b0);
    check(irq_low, 1'b0);
    host.read_status();
    tick(5);
    check(irq_low, 1'b0);
    @(posedge mclk);
    comp[3] <= 1'b1;
    tick(5);
    check(irq_low, 1'b1);
    // second fault, cleared by switching off then reading
    @(posedge mclk);
    comp[3] <= 1'b0;
    tick(5);
    check(irq_low, 1'b0);
    host.set_enable(3, 1'b0);
    tick(5);
    check(irq_low, 1'b0);
    host.read_status();
    tick(3);
    check(irq_low, 1'b1);
    // masked converter fault shows in status only
    @(posedge mclk);
    comp[0] <= 1'b0;
    tick(5);
    check(pg[0], 1'b0);
    check(irq_low, 1'b1);
    final_report();
  end
endmodule
